//--- rtl/csf_device.sv
`include "csf_defs.svh"
module csf_device #(
	parameter int CLKS_PER_MS = `CSF_TIME_BASE_NS / `CSF_MCLK_PERIOD_NS
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic arst_n_in,
	// Link to the host.
	csf_link_if.dev link,
	// Control loop side.
	input wire logic signed [31:0] pos_act_in,
	input wire logic signed [31:0] vel_act_in,
	input wire logic closed_loop_in,
	input wire logic quick_stop_in,
	// Limit switch pins.
	input wire logic lim_neg_in,
	input wire logic lim_pos_in,
	// Set-point to the control loop.
	output logic signed [31:0] setpoint_out,
	output logic [7:0] sp_mode_out,
	output logic sp_valid_out,
	output logic drive_en_out
);
	localparam int CNT_W = $clog2(CLKS_PER_MS + 1);

	typedef struct packed {
		logic [1:0] lim_s1;
		logic [1:0] lim_s2;
		logic [7:0] mode;
		logic [7:0] period;
		logic [7:0] tindex;
		logic [31:0] fe_win;
		logic [15:0] fe_tmo;
		logic [31:0] qs_dec;
		logic [7:0] qs_opt;
		logic [31:0] sw_min;
		logic [31:0] sw_max;
		logic [31:0] rng_min;
		logic [31:0] rng_max;
		logic [15:0] max_trq;
		logic [31:0] target;
		logic [CNT_W-1:0] tick_cnt;
		logic [7:0] since_tgt;
		logic synced;
		logic [15:0] fe_cnt;
		logic fe_flag;
		csf_pkg::csf_qs_state_type qs_state;
		logic [31:0] qs_vel;
		logic [31:0] sp;
		logic [7:0] sp_mode;
		logic follow;
		logic [15:0] status;
		logic [31:0] pos_act;
		logic [31:0] vel_act;
		logic [31:0] fe_act;
	} csf_dev_state_type;

	csf_dev_state_type r;
	csf_dev_state_type n;
	logic signed [31:0] pos_lim;
	logic signed [31:0] fe;
	logic signed [31:0] v;
	logic signed [31:0] tc;
	logic signed [47:0] prod;
	logic ms_tick;
	logic mode_ok;
	logic lim_neg;
	logic lim_pos;

	function automatic logic [31:0] csf_abs(input logic signed [31:0] x);
		csf_abs = x[31] ? 32'(-x) : x;
	endfunction : csf_abs

	// ----------------------------------------
	// Position limits.
	// ----------------------------------------
	csf_pos_limiter u_lim (
		.target_in(r.target),
		.sw_min_in(r.sw_min),
		.sw_max_in(r.sw_max),
		.rng_min_in(r.rng_min),
		.rng_max_in(r.rng_max),
		.pos_out(pos_lim)
	);

	// ----------------------------------------
	// Next state.
	// ----------------------------------------
	always_comb begin
		n = r;
		n.lim_s1 = {lim_pos_in, lim_neg_in};
		n.lim_s2 = r.lim_s1;
		lim_neg = r.lim_s2[0];
		lim_pos = r.lim_s2[1];
		ms_tick = (r.tick_cnt == CNT_W'(CLKS_PER_MS - 1));
		n.tick_cnt = ms_tick ? '0 : CNT_W'(r.tick_cnt + 1'b1);
		if (link.obj_wr) begin
			unique case (link.obj_idx)
				`CSF_OBJ_MODE: n.mode = link.obj_data[7:0];
				`CSF_OBJ_PERIOD: n.period = link.obj_data[7:0];
				`CSF_OBJ_TINDEX: begin
					if (link.obj_data[7:0] == `CSF_TIME_INDEX_MS) begin
						n.tindex = link.obj_data[7:0];
					end
				end
				`CSF_OBJ_FE_WIN: n.fe_win = link.obj_data;
				`CSF_OBJ_FE_TMO: n.fe_tmo = link.obj_data[15:0];
				`CSF_OBJ_QS_DEC: n.qs_dec = link.obj_data;
				`CSF_OBJ_QS_OPT: n.qs_opt = link.obj_data[7:0];
				`CSF_OBJ_SW_MIN: n.sw_min = link.obj_data;
				`CSF_OBJ_SW_MAX: n.sw_max = link.obj_data;
				`CSF_OBJ_RNG_MIN: n.rng_min = link.obj_data;
				`CSF_OBJ_RNG_MAX: n.rng_max = link.obj_data;
				`CSF_OBJ_MAX_TRQ: n.max_trq = link.obj_data[15:0];
				default: n.mode = r.mode;
			endcase
		end
		if (link.tgt_wr) begin
			n.target = link.tgt_data;
			n.since_tgt = 8'h00;
		end else if (ms_tick && r.since_tgt != 8'hff) begin
			n.since_tgt = 8'(r.since_tgt + 8'h01);
		end
		n.synced = (r.period != 8'h00) && (r.tindex == `CSF_TIME_INDEX_MS)
			&& ({1'b0, r.since_tgt} <= 9'(r.period + `CSF_SYNC_SLACK_MS));
		mode_ok = (r.mode == `CSF_MODE_CSP) || (r.mode == `CSF_MODE_CSV)
			|| ((r.mode == `CSF_MODE_CST) && closed_loop_in);

		// Quick-stop reaction.
		unique case (r.qs_state)
			csf_pkg::QS_IDLE: begin
				if (quick_stop_in) begin
					n.qs_vel = vel_act_in;
					n.qs_state = (r.qs_opt == 8'h00) ? csf_pkg::QS_OFF
						: csf_pkg::QS_BRAKE;
				end
			end
			csf_pkg::QS_BRAKE: begin
				if (csf_abs(r.qs_vel) <= r.qs_dec) begin
					if (ms_tick) begin
						n.qs_vel = '0;
						n.qs_state = (r.qs_opt >= `CSF_QS_OPT_HOLD_LO
							&& r.qs_opt <= `CSF_QS_OPT_HOLD_HI)
							? csf_pkg::QS_HOLD : csf_pkg::QS_OFF;
					end
				end else if (ms_tick) begin
					n.qs_vel = r.qs_vel[31] ? 32'(r.qs_vel + r.qs_dec)
						: 32'(r.qs_vel - r.qs_dec);
				end
			end
			csf_pkg::QS_HOLD, csf_pkg::QS_OFF: begin
				if (!quick_stop_in) begin
					n.qs_state = csf_pkg::QS_IDLE;
				end
			end
		endcase
		n.follow = mode_ok && r.synced && (r.qs_state == csf_pkg::QS_IDLE);

		// Set-point selection; control word is not consulted here.
		v = r.target;
		tc = r.target;
		prod = '0;
		if (r.qs_state != csf_pkg::QS_IDLE) begin
			n.sp = r.qs_vel;
			n.sp_mode = `CSF_MODE_CSV;
		end else if (r.follow) begin
			n.sp_mode = r.mode;
			unique case (r.mode)
				`CSF_MODE_CSP: begin
					v = pos_lim;
					if ((lim_pos && v > pos_act_in) || (lim_neg && v < pos_act_in)) begin
						v = pos_act_in;
					end
				end
				`CSF_MODE_CST: begin
					if (tc > 32'sd`CSF_TRQ_FULL_SCALE) begin
						tc = 32'sd`CSF_TRQ_FULL_SCALE;
					end else if (tc < -32'sd`CSF_TRQ_FULL_SCALE) begin
						tc = -32'sd`CSF_TRQ_FULL_SCALE;
					end
					prod = 48'(tc) * 48'(signed'({1'b0, r.max_trq}));
					v = 32'(prod / 48'sd`CSF_TRQ_FULL_SCALE);
				end
				default: v = r.target;
			endcase
			if (r.mode != `CSF_MODE_CSP && ((lim_pos && v > 0) || (lim_neg && v < 0))) begin
				v = '0;
			end
			n.sp = v;
		end

		// Following error supervision.
		fe = 32'(r.sp - pos_act_in);
		if (r.follow && r.mode == `CSF_MODE_CSP) begin
			n.fe_act = fe;
			if (csf_abs(fe) > r.fe_win) begin
				if (ms_tick && r.fe_cnt != 16'hffff) begin
					n.fe_cnt = 16'(r.fe_cnt + 16'h0001);
				end
			end else begin
				n.fe_cnt = 16'h0000;
			end
		end else begin
			n.fe_cnt = 16'h0000;
			n.fe_act = '0;
		end
		n.fe_flag = (n.fe_cnt > r.fe_tmo);
		n.status = 16'h0000;
		n.status[`CSF_SW_SYNC] = r.synced;
		n.status[`CSF_SW_FOLLOW] = r.follow;
		n.status[`CSF_SW_FERR] = r.fe_flag;
		n.pos_act = pos_act_in;
		n.vel_act = vel_act_in;
	end

	// ----------------------------------------
	// State register.
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= '0;
			r.period <= `CSF_RST_PERIOD;
			r.tindex <= `CSF_TIME_INDEX_MS;
			r.fe_win <= `CSF_RST_FE_WIN;
			r.fe_tmo <= `CSF_RST_FE_TMO;
			r.max_trq <= `CSF_RST_MAX_TRQ;
			r.since_tgt <= 8'hff;
			r.qs_state <= csf_pkg::QS_IDLE;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign link.status = r.status;
	assign link.pos_act = r.pos_act;
	assign link.vel_act = r.vel_act;
	assign link.fe_act = r.fe_act;
	assign setpoint_out = r.sp;
	assign sp_mode_out = r.sp_mode;
	assign sp_valid_out = r.follow;
	assign drive_en_out = (r.qs_state != csf_pkg::QS_OFF);
endmodule : csf_device

//--- include/csf_defs.svh
`ifndef CSF_DEFS_SVH
`define CSF_DEFS_SVH

// ----------------------------------------
// Timing.
// ----------------------------------------
`define CSF_MCLK_PERIOD_NS 50
`define CSF_TIME_BASE_NS 1000000
`define CSF_SYNC_SLACK_MS 8'h01

// ----------------------------------------
// Object indices on the link, also host write addresses.
// ----------------------------------------
`define CSF_OBJ_MODE 4'h0
`define CSF_OBJ_PERIOD 4'h1
`define CSF_OBJ_TINDEX 4'h2
`define CSF_OBJ_FE_WIN 4'h3
`define CSF_OBJ_FE_TMO 4'h4
`define CSF_OBJ_QS_DEC 4'h5
`define CSF_OBJ_QS_OPT 4'h6
`define CSF_OBJ_SW_MIN 4'h7
`define CSF_OBJ_SW_MAX 4'h8
`define CSF_OBJ_RNG_MIN 4'h9
`define CSF_OBJ_RNG_MAX 4'ha
`define CSF_OBJ_MAX_TRQ 4'hb
`define CSF_ADDR_TARGET 4'hc

// ----------------------------------------
// Host read addresses.
// ----------------------------------------
`define CSF_RD_STATUS 4'h0
`define CSF_RD_POS 4'h1
`define CSF_RD_VEL 4'h2
`define CSF_RD_FE 4'h3

// ----------------------------------------
// Mode codes, time index, status bits.
// ----------------------------------------
`define CSF_MODE_CSP 8'h08
`define CSF_MODE_CSV 8'h09
`define CSF_MODE_CST 8'h0a
`define CSF_TIME_INDEX_MS 8'hfd
`define CSF_SW_SYNC 8
`define CSF_SW_FOLLOW 12
`define CSF_SW_FERR 13
`define CSF_TRQ_FULL_SCALE 1000
`define CSF_QS_OPT_HOLD_LO 8'h05
`define CSF_QS_OPT_HOLD_HI 8'h08

// ----------------------------------------
// Reset values.
// ----------------------------------------
`define CSF_RST_PERIOD 8'h01
`define CSF_RST_FE_WIN 32'h0000_0100
`define CSF_RST_FE_TMO 16'h0064
`define CSF_RST_MAX_TRQ 16'h03e8

`endif

//--- include/csf_pkg.sv
package csf_pkg;
	typedef enum logic [1:0] {QS_IDLE, QS_BRAKE, QS_HOLD, QS_OFF} csf_qs_state_type;
	typedef logic signed [31:0] csf_word_type;
endpackage : csf_pkg

//--- include/csf_link_if.sv
interface csf_link_if;
	logic obj_wr;
	logic [3:0] obj_idx;
	logic [31:0] obj_data;
	logic tgt_wr;
	logic [31:0] tgt_data;
	logic [15:0] status;
	logic [31:0] pos_act;
	logic [31:0] vel_act;
	logic [31:0] fe_act;
	modport dev (input obj_wr, obj_idx, obj_data, tgt_wr, tgt_data,
		output status, pos_act, vel_act, fe_act);
	modport host (output obj_wr, obj_idx, obj_data, tgt_wr, tgt_data,
		input status, pos_act, vel_act, fe_act);
endinterface : csf_link_if

//--- rtl/csf_pos_limiter.sv
module csf_pos_limiter (
	// Raw target and limits.
	input wire logic signed [31:0] target_in,
	input wire logic signed [31:0] sw_min_in,
	input wire logic signed [31:0] sw_max_in,
	input wire logic signed [31:0] rng_min_in,
	input wire logic signed [31:0] rng_max_in,
	// Limited position.
	output logic signed [31:0] pos_out
);
	logic signed [31:0] span;
	logic signed [31:0] wrapped;

	always_comb begin
		span = 32'(rng_max_in - rng_min_in + 32'sd1);
		wrapped = target_in;
		if (rng_min_in < rng_max_in) begin
			if (target_in > rng_max_in) begin
				wrapped = 32'(target_in - span);
			end else if (target_in < rng_min_in) begin
				wrapped = 32'(target_in + span);
			end
		end
		pos_out = wrapped;
		if (sw_min_in < sw_max_in) begin
			if (wrapped > sw_max_in) begin
				pos_out = sw_max_in;
			end else if (wrapped < sw_min_in) begin
				pos_out = sw_min_in;
			end
		end
	end
endmodule : csf_pos_limiter

//--- rtl/csf_host.sv
`include "csf_defs.svh"
module csf_host #(
	parameter int CLKS_PER_MS = `CSF_TIME_BASE_NS / `CSF_MCLK_PERIOD_NS
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic arst_n_in,
	// Link to the device.
	csf_link_if.host link,
	// Software register port.
	input wire logic [3:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [31:0] rdata_out
);
	localparam int CNT_W = $clog2(CLKS_PER_MS + 1);

	typedef struct packed {
		logic obj_wr;
		logic [3:0] obj_idx;
		logic [31:0] obj_data;
		logic tgt_wr;
		logic [31:0] tgt_data;
		logic have_tgt;
		logic [7:0] period;
		logic [CNT_W-1:0] tick_cnt;
		logic [7:0] ms_cnt;
		logic [31:0] rdata;
	} csf_host_state_type;

	csf_host_state_type r;
	csf_host_state_type n;
	logic ms_tick;

	// ----------------------------------------
	// Next state.
	// ----------------------------------------
	always_comb begin
		n = r;
		n.obj_wr = 1'b0;
		n.tgt_wr = 1'b0;
		n.rdata = '0;
		ms_tick = (r.tick_cnt == CNT_W'(CLKS_PER_MS - 1));
		n.tick_cnt = ms_tick ? '0 : CNT_W'(r.tick_cnt + 1'b1);
		if (ms_tick) begin
			n.ms_cnt = 8'(r.ms_cnt + 8'h01);
		end
		if (wr_in && addr_in == `CSF_ADDR_TARGET) begin
			n.tgt_wr = 1'b1;
			n.tgt_data = wdata_in;
			n.have_tgt = 1'b1;
			n.ms_cnt = 8'h00;
		end else if (ms_tick && r.have_tgt && 8'(r.ms_cnt + 8'h01) >= r.period) begin
			n.tgt_wr = 1'b1;
			n.ms_cnt = 8'h00;
		end
		if (wr_in && addr_in < `CSF_ADDR_TARGET) begin
			n.obj_wr = 1'b1;
			n.obj_idx = addr_in;
			n.obj_data = wdata_in;
			if (addr_in == `CSF_OBJ_PERIOD) begin
				n.period = wdata_in[7:0];
			end
		end
		if (rd_in) begin
			unique case (addr_in)
				`CSF_RD_STATUS: n.rdata = {16'h0000, link.status};
				`CSF_RD_POS: n.rdata = link.pos_act;
				`CSF_RD_VEL: n.rdata = link.vel_act;
				`CSF_RD_FE: n.rdata = link.fe_act;
				default: n.rdata = '0;
			endcase
		end
	end

	// ----------------------------------------
	// State register.
	// ----------------------------------------
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r <= '0;
			r.period <= `CSF_RST_PERIOD;
		end else begin
			r <= n;
		end
	end

	// ----------------------------------------
	// Outputs.
	// ----------------------------------------
	assign link.obj_wr = r.obj_wr;
	assign link.obj_idx = r.obj_idx;
	assign link.obj_data = r.obj_data;
	assign link.tgt_wr = r.tgt_wr;
	assign link.tgt_data = r.tgt_data;
	assign rdata_out = r.rdata;
endmodule : csf_host

//--- verification/csf_asserts.sv
`include "csf_defs.svh"
module csf_asserts #(
	parameter int CLKS_PER_MS = `CSF_TIME_BASE_NS / `CSF_MCLK_PERIOD_NS
) (
	// Clock and reset.
	input wire logic mclk_in,
	input wire logic arst_n_in,
	// Host to device.
	input wire logic obj_wr,
	input wire logic [3:0] obj_idx,
	input wire logic [31:0] obj_data,
	input wire logic tgt_wr,
	input wire logic [31:0] tgt_data,
	// Device to host.
	input wire logic [15:0] status,
	input wire logic [31:0] pos_act,
	input wire logic [31:0] vel_act,
	input wire logic [31:0] fe_act
);
	logic [7:0] per_r;
	logic [7:0] mode_r;
	logic [31:0] win_r;
	logic [15:0] tmo_r;
	logic [31:0] oob_r;
	logic in_band;

	// ----------------------------------------
	// Shadow copies of four objects written over the link, and an out-of-band cycle counter.
	// ----------------------------------------
	assign in_band = ($signed(fe_act) <= $signed(win_r)) && ($signed(fe_act) >= -$signed(win_r));
	always_ff @(posedge mclk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			per_r <= `CSF_RST_PERIOD;
			mode_r <= 8'h00;
			win_r <= `CSF_RST_FE_WIN;
			tmo_r <= `CSF_RST_FE_TMO;
			oob_r <= 32'h0;
		end else begin
			if (obj_wr) begin
				case (obj_idx)
					`CSF_OBJ_PERIOD: per_r <= obj_data[7:0];
					`CSF_OBJ_MODE: mode_r <= obj_data[7:0];
					`CSF_OBJ_FE_WIN: win_r <= obj_data;
					`CSF_OBJ_FE_TMO: tmo_r <= obj_data[15:0];
					default: ;
				endcase
			end
			oob_r <= in_band ? 32'h0 : oob_r + 32'h1;
		end
	end

	// ----------------------------------------
	// Properties.
	// ----------------------------------------
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!arst_n_in);

	a_sync_on_target: assert property (tgt_wr && per_r != 8'h00 ##1 per_r != 8'h00 [*3]
		|-> status[8]) else $error("sync bit missing after target");
	a_sync_no_period: assert property ((per_r == 8'h00) [*4] |-> !status[8])
		else $error("sync bit set with zero period");
	a_status_spare: assert property ((status & 16'hceff) == 16'h0)
		else $error("status bit outside the documented set");
	a_fe_idle: assert property ((!status[12]) [*3] |-> fe_act == 32'h0)
		else $error("following error shown while not following");
	a_follow_mode: assert property
		((!(mode_r inside {`CSF_MODE_CSP, `CSF_MODE_CSV, `CSF_MODE_CST})) [*4] |-> !status[12])
		else $error("follow bit set outside cyclic modes");
	a_follow_sync: assert property (status[12] && !status[8] |=> !status[12])
		else $error("follow bit kept after sync loss");
	a_ferr_clears: assert property (status[13] && in_band && mode_r == `CSF_MODE_CSP
		|-> ##2 !status[13]) else $error("following error kept inside band");
	a_ferr_not_early: assert property ($rose(status[13])
		|-> oob_r + 32'h2 >= tmo_r * CLKS_PER_MS) else $error("following error before timeout");
endmodule : csf_asserts

//--- verification/csf_tb.sv
`include "csf_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
	$display("wrong value at %0t: %h not %h", $time, (g), (e)); end end
module csf_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic signed [31:0] pos_act_in = 32'h0;
	logic signed [31:0] vel_act_in = 32'h0;
	logic closed_loop_in = 1'b0;
	logic quick_stop_in = 1'b0;
	logic lim_neg_in = 1'b0;
	logic lim_pos_in = 1'b0;
	logic signed [31:0] setpoint_out;
	logic [7:0] sp_mode_out;
	logic sp_valid_out;
	logic drive_en_out;
	logic [31:0] rnd = 32'he33b;
	logic [31:0] rv;
	logic signed [31:0] tv;
	logic signed [31:0] tq [3] = '{32'h190, 32'h5dc, 32'hffff_f830};
	logic [31:0] opts [3] = '{32'h5, 32'h0, 32'h2};
	int errors = 0;
	int cmp_count = 0;
	int cycles = 0;

	always #25 mclk_in = ~mclk_in;
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 4000) begin
			errors++;
			$display("wrong value at %0t: run hung", $time);
			wrap_up();
		end
	end

	csf_link_if link ();
	csf_host #(.CLKS_PER_MS(20)) u_csf_host (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.link(link.host), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
		.rd_in(rd_in), .rdata_out(rdata_out));
	csf_device #(.CLKS_PER_MS(20)) u_csf_device (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.link(link.dev), .pos_act_in(pos_act_in), .vel_act_in(vel_act_in),
		.closed_loop_in(closed_loop_in), .quick_stop_in(quick_stop_in), .lim_neg_in(lim_neg_in),
		.lim_pos_in(lim_pos_in), .setpoint_out(setpoint_out), .sp_mode_out(sp_mode_out),
		.sp_valid_out(sp_valid_out), .drive_en_out(drive_en_out));
	csf_asserts #(.CLKS_PER_MS(20)) u_csf_asserts (.mclk_in(mclk_in), .arst_n_in(arst_n_in),
		.obj_wr(link.obj_wr), .obj_idx(link.obj_idx), .obj_data(link.obj_data),
		.tgt_wr(link.tgt_wr), .tgt_data(link.tgt_data), .status(link.status),
		.pos_act(link.pos_act), .vel_act(link.vel_act), .fe_act(link.fe_act));

	// ----------------------------------------
	// Helpers.
	// ----------------------------------------
	function automatic logic signed [31:0] trq_exp(input logic signed [31:0] t, input int m);
		logic signed [31:0] c;
		c = (t > `CSF_TRQ_FULL_SCALE) ? `CSF_TRQ_FULL_SCALE : t;
		c = (c < -`CSF_TRQ_FULL_SCALE) ? -`CSF_TRQ_FULL_SCALE : c;
		return c * m / `CSF_TRQ_FULL_SCALE;
	endfunction : trq_exp

	function automatic logic signed [31:0] draw();
		rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
		return {{16{rnd[15]}}, rnd[15:0]};
	endfunction : draw

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge mclk_in);
		wr_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge mclk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		@(negedge mclk_in);
		d = rdata_out;
	endtask : rd

	task automatic tgt(input logic [31:0] v);
		wr(`CSF_ADDR_TARGET, v);
		repeat (8) @(negedge mclk_in);
	endtask : tgt

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : wrap_up

	// ----------------------------------------
	// Tests.
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge mclk_in);
		arst_n_in <= 1'b1;
		rd(`CSF_RD_STATUS, rv);
		`CHK(rv, 32'h0)
		`CHK(sp_valid_out, 1'b0)
		wr(4'hd, 32'h5);
		rd(4'h5, rv);
		`CHK(rv, 32'h0)
		$display("test reset done");
		wr(`CSF_OBJ_MODE, 32'h8);
		for (int i = 0; i < 4; i++) begin
			tv = draw();
			@(posedge mclk_in);
			pos_act_in <= tv - 32'h20;
			vel_act_in <= -tv;
			tgt(tv);
			`CHK(setpoint_out, tv)
			`CHK(sp_mode_out, `CSF_MODE_CSP)
			rd(`CSF_RD_STATUS, rv);
			`CHK(rv[13:8], 6'h11)
			rd(`CSF_RD_FE, rv);
			`CHK(rv, 32'h20)
			rd(`CSF_RD_POS, rv);
			`CHK(rv, tv - 32'h20)
			rd(`CSF_RD_VEL, rv);
			`CHK(rv, -tv)
		end
		repeat (80) @(negedge mclk_in);
		`CHK(setpoint_out, tv)
		`CHK(link.status[8], 1'b1)
		$display("test position follow done");
		wr(`CSF_OBJ_SW_MIN, 32'hffff_fc18);
		wr(`CSF_OBJ_SW_MAX, 32'h3e8);
		tgt(32'h1388);
		`CHK(setpoint_out, 32'sh3e8)
		tgt(32'hffff_ec78);
		`CHK(setpoint_out, 32'shffff_fc18)
		wr(`CSF_OBJ_SW_MIN, 32'h0);
		wr(`CSF_OBJ_SW_MAX, 32'h0);
		@(posedge mclk_in);
		pos_act_in <= 32'h64;
		tgt(32'h64);
		wr(`CSF_OBJ_FE_WIN, 32'h10);
		wr(`CSF_OBJ_FE_TMO, 32'h2);
		@(posedge mclk_in);
		pos_act_in <= 32'h0;
		tgt(32'h64);
		repeat (30) @(negedge mclk_in);
		`CHK(link.status[13], 1'b0)
		repeat (40) @(negedge mclk_in);
		`CHK(link.status[13], 1'b1)
		@(posedge mclk_in);
		pos_act_in <= 32'h64;
		repeat (5) @(negedge mclk_in);
		`CHK(link.status[13], 1'b0)
		wr(`CSF_OBJ_FE_WIN, `CSF_RST_FE_WIN);
		wr(`CSF_OBJ_FE_TMO, 32'h64);
		$display("test limits and following error done");
		wr(`CSF_OBJ_MODE, 32'h9);
		tv = draw();
		tgt(tv);
		`CHK(setpoint_out, tv)
		`CHK(sp_mode_out, `CSF_MODE_CSV)
		rd(`CSF_RD_FE, rv);
		`CHK(rv, 32'h0)
		tgt(32'h1f4);
		@(posedge mclk_in);
		lim_pos_in <= 1'b1;
		repeat (6) @(negedge mclk_in);
		`CHK(setpoint_out, 32'sh0)
		tgt(32'hffff_fe0c);
		`CHK(setpoint_out, 32'shffff_fe0c)
		@(posedge mclk_in);
		lim_neg_in <= 1'b1;
		repeat (6) @(negedge mclk_in);
		`CHK(setpoint_out, 32'sh0)
		@(posedge mclk_in);
		lim_neg_in <= 1'b0;
		lim_pos_in <= 1'b0;
		$display("test velocity and switches done");
		wr(`CSF_OBJ_MODE, 32'ha);
		wr(`CSF_OBJ_MAX_TRQ, 32'h1f4);
		tgt(32'h190);
		`CHK(sp_valid_out, 1'b0)
		`CHK(link.status[12], 1'b0)
		@(posedge mclk_in);
		closed_loop_in <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (i < 3) begin
				tv = tq[i];
			end else begin
				tv = draw();
			end
			tgt(tv);
			`CHK(setpoint_out, trq_exp(tv, 500))
			`CHK(sp_mode_out, `CSF_MODE_CST)
		end
		$display("test torque done");
		wr(`CSF_OBJ_MODE, 32'h9);
		@(posedge mclk_in);
		vel_act_in <= 32'h64;
		wr(`CSF_OBJ_QS_DEC, 32'h1e);
		for (int i = 0; i < 3; i++) begin
			wr(`CSF_OBJ_QS_OPT, opts[i]);
			@(posedge mclk_in);
			quick_stop_in <= 1'b1;
			repeat (5) @(negedge mclk_in);
			`CHK(drive_en_out, (opts[i] != 32'h0))
			if (opts[i] != 32'h0) begin
				`CHK((setpoint_out == 32'sh64) || (setpoint_out == 32'sh46), 1'b1)
				`CHK(sp_mode_out, `CSF_MODE_CSV)
			end
			repeat (120) @(negedge mclk_in);
			`CHK(drive_en_out, (opts[i] == 32'h5))
			if (opts[i] == 32'h5) begin
				`CHK(setpoint_out, 32'sh0)
			end
			@(posedge mclk_in);
			quick_stop_in <= 1'b0;
			repeat (5) @(negedge mclk_in);
		end
		$display("test quick stop done");
		wr(`CSF_OBJ_TINDEX, 32'hfe);
		wr(`CSF_OBJ_PERIOD, 32'h2);
		repeat (150) @(negedge mclk_in);
		`CHK(link.status[8], 1'b1)
		wr(`CSF_OBJ_PERIOD, 32'h0);
		repeat (10) @(negedge mclk_in);
		`CHK(link.status[8], 1'b0)
		`CHK(sp_valid_out, 1'b0)
		$display("test cycle time done");
		wrap_up();
	end
endmodule : csf_tb
